// file: design/ifab_ctrl.sv
// Backplane control: converter registers, band latch, status return
// How it works
// - Each gain converter is 12 bits, written as two byte transfers.
// - Addresses 50h-53h: front low, front high, mid low, mid high.
// - Addresses 54h-57h: end-to-end converter, then unused spare converter.
// - Low address loads bits 0-7; high address loads data 3:0 as 11:8.
// - Any write to 58h moves all four held values to outputs.
// - Latch 59h bits 2:0 hold the bandwidth code.
// - Latch bit 3 enables bandwidth selection.
// - Code plus enable decode into individual bandwidth select lines.
// - Latch bit 4: 0 high band, 1 low bands.
// - High/low select also steers own input selector.
// - Latch bit 5: 1 band 1, 0 band 2.
// - Band, high/low and wideband selects driven onto backplane.
// - Front and mid converters set attenuators with gain control allowed.
// - End-to-end converter alone sets fourth attenuator, never gain control.
// - Underload reported only after 200 us uninterrupted; interruptions retrigger.
// - Overload is stretched then tristate-driven onto two overload lines.
// - Filter bandwidth select lines are active low.
`timescale 1ns/100ps
`default_nettype none
module ifab_ctrl #(
    parameter int UNDERLOAD_CYC = ifab_pkg::UNDERLOAD_CYC,
    parameter int STRETCH_CYC   = ifab_pkg::STRETCH_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [7:0]  bus_data,
    input  wire logic        bus_wr,
    input  wire logic        overload_in,
    input  wire logic        underload_in,
    output logic [11:0]      front_gain,
    output logic [11:0]      mid_gain,
    output logic [11:0]      end_gain,
    output logic [11:0]      spare_gain,
    output logic             agc_path_closed,
    output logic             front_agc_en,
    output logic             mid_agc_en,
    output logic             end_agc_en,
    output logic [4:0]       bw_sel_n,
    output logic             wideband_sel,
    output logic             low_band_sel,
    output logic             band1_sel,
    output logic             input_lowfreq_sel,
    output logic             underload_out,
    output logic             underload_oe,
    output logic             combined_ovl_out,
    output logic             combined_ovl_oe,
    output logic             discrete_ovl_out,
    output logic             discrete_ovl_oe
);
    initial
    begin
        if (UNDERLOAD_CYC < 1 || STRETCH_CYC < 1)
            $error("ifab_ctrl: counts must be at least one");
    end

    // Pin synchronisers; first stage feeds only the second
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [7:0] addr_s;
    logic [7:0] data_s;

    logic [7:0] addr1_r;
    logic [7:0] addr2_r;
    logic [7:0] data1_r;
    logic [7:0] data2_r;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            addr1_r <= 8'h00;
            addr2_r <= 8'h00;
            data1_r <= 8'h00;
            data2_r <= 8'h00;
        end
        else
        begin
            sync1_r <= {bus_wr, underload_in, overload_in};
            sync2_r <= sync1_r;
            addr1_r <= bus_addr;
            addr2_r <= addr1_r;
            data1_r <= bus_data;
            data2_r <= data1_r;
        end
    end

    assign addr_s           = addr2_r;
    assign data_s           = data2_r;

    logic wr_s;
    logic wr_d_r;
    logic wr_edge;
    logic ovl_s;
    logic unl_s;

    assign ovl_s = sync2_r[0];
    assign unl_s = sync2_r[1];
    assign wr_s  = sync2_r[2];

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            wr_d_r <= 1'b0;
        else
            wr_d_r <= wr_s;
    end

    // One write per strobe; address and data held stable around the strobe
    assign wr_edge = wr_s && !wr_d_r;

    // Address decode
    logic [3:0] hit_lo;
    logic [3:0] hit_hi;
    logic       hit_load;
    logic       hit_latch;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_dec
            assign hit_lo[g] = wr_edge &&
                (addr_s == ifab_pkg::ADDR_FRONT_LO + 8'(2 * g));
            assign hit_hi[g] = wr_edge &&
                (addr_s == ifab_pkg::ADDR_FRONT_HI + 8'(2 * g));
        end
    endgenerate

    assign hit_load  = wr_edge && (addr_s == ifab_pkg::ADDR_LOAD);
    assign hit_latch = wr_edge && (addr_s == ifab_pkg::ADDR_LATCH);

    // Holding and output registers, one set per converter
    logic [11:0] hold_r [4];
    logic [11:0] out_r  [4];

    generate
        for (g = 0; g < 4; g++)
        begin : g_conv
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    hold_r[g] <= ifab_pkg::CONV_RESET;
                else if (hit_lo[g])
                    hold_r[g][7:0] <= data_s;
                else if (hit_hi[g])
                    hold_r[g][11:8] <= data_s[3:0];
            end

            // Outputs move only on the load strobe, so a half-written value never shows
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    out_r[g] <= ifab_pkg::CONV_RESET;
                else if (hit_load)
                    out_r[g] <= hold_r[g];
            end
        end
    endgenerate

    assign front_gain = out_r[0];
    assign mid_gain   = out_r[1];
    assign end_gain   = out_r[2];
    assign spare_gain = out_r[3];

    // Control latch
    logic [7:0] latch_r;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            latch_r <= ifab_pkg::LATCH_RESET;
        else if (hit_latch)
            latch_r <= data_s;
    end

    logic [2:0] bw_code;
    logic       bw_en;
    logic       agc_en;

    assign bw_code = latch_r[ifab_pkg::LAT_BW_MSB:ifab_pkg::LAT_BW_LSB];
    assign bw_en   = latch_r[ifab_pkg::LAT_BW_EN];
    assign agc_en  = latch_r[ifab_pkg::LAT_AGC_EN];

    // Select lines: 15M, 4M, 1M, 300k, 80k; reserved and unused codes select none
    logic [4:0] bw_onehot;
    logic       wide_nxt;

    assign bw_onehot[0] = bw_en && (bw_code == ifab_pkg::BW_15M);
    assign bw_onehot[1] = bw_en && (bw_code == ifab_pkg::BW_4M);
    assign bw_onehot[2] = bw_en && (bw_code == ifab_pkg::BW_1M);
    assign bw_onehot[3] = bw_en && (bw_code == ifab_pkg::BW_300K);
    assign bw_onehot[4] = bw_en && (bw_code == ifab_pkg::BW_80K);
    assign wide_nxt     = bw_en && (bw_code == ifab_pkg::BW_WIDE);

    // Registered pin outputs
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bw_sel_n          <= 5'h1F;
            wideband_sel      <= 1'b0;
            low_band_sel      <= 1'b0;
            band1_sel         <= 1'b0;
            input_lowfreq_sel <= 1'b0;
            agc_path_closed   <= 1'b0;
            front_agc_en      <= 1'b0;
            mid_agc_en        <= 1'b0;
            end_agc_en        <= 1'b0;
        end
        else
        begin
            bw_sel_n          <= ~bw_onehot;
            wideband_sel      <= wide_nxt;
            low_band_sel      <= latch_r[ifab_pkg::LAT_LOW_BAND];
            band1_sel         <= latch_r[ifab_pkg::LAT_BAND1];
            input_lowfreq_sel <= latch_r[ifab_pkg::LAT_LOW_BAND];
            agc_path_closed   <= agc_en;
            front_agc_en      <= agc_en;
            mid_agc_en        <= agc_en;
            end_agc_en        <= 1'b0;
        end
    end

    // Status return
    logic unl_qual;
    logic ovl_str;

    ifab_qual #(
        .QUAL_CYC    (UNDERLOAD_CYC),
        .STRETCH_CYC (STRETCH_CYC)
    ) u_unl (
        .clock     (clock),
        .rst       (rst),
        .level_in  (unl_s),
        .pulse_in  (1'b0),
        .qualified (unl_qual),
        .stretched ()
    );

    ifab_qual #(
        .QUAL_CYC    (1),
        .STRETCH_CYC (STRETCH_CYC)
    ) u_ovl (
        .clock     (clock),
        .rst       (rst),
        .level_in  (1'b0),
        .pulse_in  (ovl_s),
        .qualified (),
        .stretched (ovl_str)
    );

    // Status lines drive only while asserted, so other modules may share them
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            underload_out    <= 1'b0;
            underload_oe     <= 1'b0;
            combined_ovl_out <= 1'b0;
            combined_ovl_oe  <= 1'b0;
            discrete_ovl_out <= 1'b0;
            discrete_ovl_oe  <= 1'b0;
        end
        else
        begin
            underload_out    <= unl_qual;
            underload_oe     <= unl_qual;
            combined_ovl_out <= ovl_str;
            combined_ovl_oe  <= ovl_str;
            discrete_ovl_out <= ovl_str;
            discrete_ovl_oe  <= ovl_str;
        end
    end

endmodule
`default_nettype wire

// file: design/ifab_pkg.sv
// Constants for the IF amplifier backplane control block
package ifab_pkg;
    localparam int          CONV_W         = 12;
    localparam int          BUS_W          = 8;
    localparam logic [7:0]  ADDR_FRONT_LO  = 8'h50;
    localparam logic [7:0]  ADDR_FRONT_HI  = 8'h51;
    localparam logic [7:0]  ADDR_MID_LO    = 8'h52;
    localparam logic [7:0]  ADDR_MID_HI    = 8'h53;
    localparam logic [7:0]  ADDR_END_LO    = 8'h54;
    localparam logic [7:0]  ADDR_END_HI    = 8'h55;
    localparam logic [7:0]  ADDR_SPARE_LO  = 8'h56;
    localparam logic [7:0]  ADDR_SPARE_HI  = 8'h57;
    localparam logic [7:0]  ADDR_LOAD      = 8'h58;
    localparam logic [7:0]  ADDR_LATCH     = 8'h59;
    localparam int          LAT_BW_LSB     = 0;
    localparam int          LAT_BW_MSB     = 2;
    localparam int          LAT_BW_EN      = 3;
    localparam int          LAT_LOW_BAND   = 4;
    localparam int          LAT_BAND1      = 5;
    localparam int          LAT_AGC_EN     = 6;
    localparam logic [7:0]  LATCH_RESET    = 8'h00;
    localparam logic [11:0] CONV_RESET     = 12'h000;
    localparam logic [2:0]  BW_15M         = 3'h0;
    localparam logic [2:0]  BW_8M_RSVD     = 3'h1;
    localparam logic [2:0]  BW_4M          = 3'h2;
    localparam logic [2:0]  BW_1M          = 3'h3;
    localparam logic [2:0]  BW_300K        = 3'h4;
    localparam logic [2:0]  BW_80K         = 3'h5;
    localparam logic [2:0]  BW_UNUSED      = 3'h6;
    localparam logic [2:0]  BW_WIDE        = 3'h7;
    localparam int          CLK_MHZ        = 100;
    localparam int          UNDERLOAD_US   = 200;
    localparam int          UNDERLOAD_CYC  = UNDERLOAD_US * CLK_MHZ;
    localparam int          STRETCH_NS     = 1000;
    localparam int          STRETCH_CYC    = STRETCH_NS * CLK_MHZ / 1000;
endpackage

// file: design/ifab_qual.sv
// Retriggerable qualify timer and pulse stretcher for one status input
`timescale 1ns/100ps
`default_nettype none
module ifab_qual #(
    parameter int QUAL_CYC    = 20000,
    parameter int STRETCH_CYC = 100
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic level_in,
    input  wire logic pulse_in,
    output logic      qualified,
    output logic      stretched
);
    localparam int QW = $clog2(QUAL_CYC + 1);
    localparam int SW = $clog2(STRETCH_CYC + 1);

    initial
    begin
        if (QUAL_CYC < 1 || STRETCH_CYC < 1)
            $error("ifab_qual: counts must be at least one");
    end

    logic [QW-1:0] qual_cnt_r;
    logic [SW-1:0] str_cnt_r;
    logic          qual_done;
    logic          str_busy;

    assign qual_done = (qual_cnt_r == QW'(QUAL_CYC));
    assign str_busy  = (str_cnt_r != '0);

    // Any drop of the level restarts the interval from zero
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            qual_cnt_r <= '0;
        else if (!level_in)
            qual_cnt_r <= '0;
        else if (!qual_done)
            qual_cnt_r <= qual_cnt_r + QW'(1);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            str_cnt_r <= '0;
        else if (pulse_in)
            str_cnt_r <= SW'(STRETCH_CYC);
        else if (str_busy)
            str_cnt_r <= str_cnt_r - SW'(1);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            qualified <= 1'b0;
            stretched <= 1'b0;
        end
        else
        begin
            qualified <= level_in && qual_done;
            stretched <= pulse_in || str_busy;
        end
    end
endmodule
`default_nettype wire

// file: tb/if_amp_backplane_control_test.sv
// Directed test of the backplane control block
`timescale 1ns/100ps
`default_nettype none
module if_amp_backplane_control_test;
    localparam logic [7:0] CONV_BYTES [8] = '{8'hAB, 8'hF3, 8'h12, 8'hA5,
                                              8'hFF, 8'h0F, 8'h01, 8'h70};
    localparam logic [4:0] BW_EXP [8] = '{5'h1E, 5'h1F, 5'h1D, 5'h1B,
                                          5'h17, 5'h0F, 5'h1F, 5'h1F};
    logic        clock        = 1'b0;
    logic        rst          = 1'b1;
    logic        overload_in  = 1'b0;
    logic        underload_in = 1'b0;
    logic [7:0]  bus_addr, bus_data;
    logic        bus_wr;
    logic [11:0] front_gain, mid_gain, end_gain, spare_gain;
    logic        agc_path_closed, front_agc_en, mid_agc_en, end_agc_en;
    logic [4:0]  bw_sel_n;
    logic        wideband_sel, low_band_sel, band1_sel, input_lowfreq_sel;
    logic        underload_out, underload_oe, combined_ovl_out, combined_ovl_oe;
    logic        discrete_ovl_out, discrete_ovl_oe;
    logic [2:0]  code;
    logic        en;
    int          num_errors = 0;
    int          tests_run  = 0;

    always #5 clock = ~clock;

    ifab_cpu_model cpu (.clock(clock), .bus_addr(bus_addr), .bus_data(bus_data), .bus_wr(bus_wr));
    ifab_ctrl #(.UNDERLOAD_CYC(20), .STRETCH_CYC(4)) uut (.*);

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reset;
        chk({front_gain, mid_gain, end_gain, spare_gain}, 48'h0);
        chk({bw_sel_n, wideband_sel, low_band_sel, band1_sel, agc_path_closed, underload_oe,
            combined_ovl_oe, discrete_ovl_oe}, 12'hF80);
    endtask

    task automatic tally_and_finish;
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        chk_reset();
        for (int i = 0; i < 8; i++)
            cpu.wr(8'h50 + 8'(i), CONV_BYTES[i]);
        cpu.wr(8'h5A, 8'hFF);
        cpu.wr(8'h4F, 8'hFF);
        chk({front_gain, mid_gain, end_gain, spare_gain}, 48'h0);
        cpu.wr(ifab_pkg::ADDR_LOAD, 8'hC3);
        chk({front_gain, mid_gain, end_gain, spare_gain},
            48'h3AB512FFF001);
        cpu.wr(ifab_pkg::ADDR_FRONT_LO, 8'h00);
        chk(front_gain, 12'h3AB);
        cpu.wr(ifab_pkg::ADDR_LOAD, 8'h00);
        chk(front_gain, 12'h300);
        // Last pass disables selection with a code that would pick a filter
        for (int i = 0; i < 9; i++)
        begin
            code = i[2:0];
            en = (i < 8);
            cpu.wr({1'b0, ~code, en, code}, 8'h00);
            cpu.wr(ifab_pkg::ADDR_LATCH, {1'b0, ~code, en, code});
            chk({bw_sel_n, wideband_sel},
                {en ? BW_EXP[code] : 5'h1F, en && code == 3'h7});
            chk({low_band_sel, input_lowfreq_sel, band1_sel},
                {~code[0], ~code[0], ~code[1]});
            chk({agc_path_closed, front_agc_en, mid_agc_en, end_agc_en},
                {{3{~code[2]}}, 1'b0});
        end
        // Short gap must restart the qualify interval
        underload_in = 1'b1;
        repeat (15) @(negedge clock);
        underload_in = 1'b0;
        @(negedge clock);
        underload_in = 1'b1;
        repeat (15) @(negedge clock);
        chk(underload_oe, 1'b0);
        repeat (15) @(negedge clock);
        chk({underload_out, underload_oe}, 2'h3);
        underload_in = 1'b0;
        repeat (8) @(negedge clock);
        chk(underload_oe, 1'b0);
        overload_in = 1'b1;
        @(negedge clock);
        overload_in = 1'b0;
        repeat (4) @(negedge clock);
        chk({combined_ovl_out, combined_ovl_oe, discrete_ovl_out, discrete_ovl_oe},
            4'hF);
        repeat (10) @(negedge clock);
        chk({combined_ovl_out, combined_ovl_oe, discrete_ovl_out, discrete_ovl_oe},
            4'h0);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        chk_reset();
        tally_and_finish();
    end

    // Generous margin over the directed sequence
    initial
    begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: tb/ifab_cpu_model.sv
// Behavioural control processor issuing backplane writes
`timescale 1ns/100ps
`default_nettype none
module ifab_cpu_model (
    input  wire logic      clock,
    output var logic [7:0] bus_addr,
    output var logic [7:0] bus_data,
    output var logic       bus_wr
);
    initial
    begin
        bus_addr = 8'hFF;
        bus_data = 8'h00;
        bus_wr   = 1'b0;
    end
    // One byte per transfer; address and data outlive the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_data = d;
        repeat (3) @(negedge clock);
        bus_wr = 1'b1;
        repeat (3) @(negedge clock);
        bus_wr = 1'b0;
        repeat (4) @(negedge clock);
        // Released bus is not left showing a stale value
        bus_addr = ~a;
        bus_data = ~d;
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

// file: tb/ifab_ctrl_checker.sv
// Port-level assertions for the backplane control block
`timescale 1ns/100ps
`default_nettype none
module ifab_ctrl_checker #(
    parameter int UNDERLOAD_CYC = 20,
    parameter int STRETCH_CYC   = 4
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  bus_addr,
    input wire logic        overload_in,
    input wire logic        underload_in,
    input wire logic [11:0] front_gain,
    input wire logic [11:0] mid_gain,
    input wire logic [11:0] end_gain,
    input wire logic [11:0] spare_gain,
    input wire logic        agc_path_closed,
    input wire logic        front_agc_en,
    input wire logic        end_agc_en,
    input wire logic [4:0]  bw_sel_n,
    input wire logic        wideband_sel,
    input wire logic        low_band_sel,
    input wire logic        band1_sel,
    input wire logic        input_lowfreq_sel,
    input wire logic        underload_oe,
    input wire logic        combined_ovl_out,
    input wire logic        combined_ovl_oe,
    input wire logic        discrete_ovl_out,
    input wire logic        discrete_ovl_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Depths assume the short qualify and stretch counts used in test
    sequence s_ul_held; $past(underload_in, 8) && $past(underload_in, 16); endsequence
    sequence s_ovl_quiet; !$past(overload_in, 2) && !$past(overload_in, 4); endsequence
    property p_ul_qual; $rose(underload_oe) |-> s_ul_held; endproperty
    a_ul_qual: assert property (p_ul_qual) else $error("underload flagged early");
    property p_conv_load;
        ($changed(front_gain) || $changed(mid_gain) || $changed(end_gain) || $changed(spare_gain))
            |-> $past(bus_addr) == ifab_pkg::ADDR_LOAD;
    endproperty
    a_conv_load: assert property (p_conv_load) else $error("gain moved without load");
    property p_latch_src;
        ($changed(low_band_sel) || $changed(band1_sel) || $changed(agc_path_closed)
            || $changed(wideband_sel)) |-> $past(bus_addr, 2) == ifab_pkg::ADDR_LATCH;
    endproperty
    a_latch_src: assert property (p_latch_src) else $error("select moved wrongly");
    property p_end_agc; !end_agc_en; endproperty
    a_end_agc: assert property (p_end_agc) else $error("fourth stage took agc");
    property p_agc_tie; front_agc_en == agc_path_closed; endproperty
    a_agc_tie: assert property (p_agc_tie) else $error("agc path mismatch");
    property p_input_sel; input_lowfreq_sel == low_band_sel; endproperty
    a_input_sel: assert property (p_input_sel) else $error("input selector mismatch");
    property p_bw_single; $countones(~bw_sel_n) <= 1 && !(wideband_sel && bw_sel_n != 5'h1F);
    endproperty
    a_bw_single: assert property (p_bw_single) else $error("several filters selected");
    property p_ovl_rise; overload_in |-> ##[1:6] (combined_ovl_out && combined_ovl_oe); endproperty
    a_ovl_rise: assert property (p_ovl_rise) else $error("overload not reported");
    property p_ovl_same;
        {combined_ovl_out, combined_ovl_oe} == {discrete_ovl_out, discrete_ovl_oe};
    endproperty
    a_ovl_same: assert property (p_ovl_same) else $error("overload lines differ");
    property p_ovl_hold; $fell(combined_ovl_oe) |-> s_ovl_quiet; endproperty
    a_ovl_hold: assert property (p_ovl_hold) else $error("overload not stretched");
endmodule
bind ifab_ctrl ifab_ctrl_checker #(
    .UNDERLOAD_CYC(UNDERLOAD_CYC),
    .STRETCH_CYC  (STRETCH_CYC)
) chk (.*);
`default_nettype wire
